// ==== hw/eiu_pkg.sv ====
// eiu_pkg: shared constants and carriers for the external interrupt unit
// assumes a single system clock; all control arrives as plain ports
package eiu_pkg;
    localparam int NUM_LINES = 8;
    localparam int SYNC_STAGES = 2;
    localparam int VOTE_DEPTH = 3;
    localparam logic [NUM_LINES-1:0] LINES_RST = 8'h00;

    typedef logic [NUM_LINES-1:0] eiu_lines_t;

    // static per-line sensing configuration
    typedef struct packed {
        eiu_lines_t level_mode;   // 0 edge, 1 level
        eiu_lines_t edge_rise;    // edge: 0 falling, 1 rising
        eiu_lines_t level_high;   // level: 0 low, 1 high
        eiu_lines_t filter_on;
        eiu_lines_t async_mode;
    } eiu_cfg_s;

    // write-one strobes, one cycle each
    typedef struct packed {
        eiu_lines_t enable_set;
        eiu_lines_t enable_clr;
        eiu_lines_t prop_set;
        eiu_lines_t prop_clr;
        eiu_lines_t pend_clr;
    } eiu_cmd_s;

    // majority of three samples
    function automatic logic eiu_vote(input logic [2:0] s);
        eiu_vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : eiu_vote
endpackage : eiu_pkg

// ==== hw/eiu_sense.sv ====
// eiu_sense: one line's synchroniser, condition, filter and trigger detect
// assumes pin is asynchronous to CLK_SYS; config held stable by software
`timescale 1ns/1ps
module eiu_sense (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    input wire logic level_mode,
    input wire logic edge_rise,
    input wire logic level_high,
    input wire logic filter_on,
    input wire logic async_mode,
    output logic trig,
    output logic async_hit
);
    import eiu_pkg::*;

    logic [SYNC_STAGES-1:0] sync;
    logic [SYNC_STAGES-1:0] next_sync;
    logic [VOTE_DEPTH-1:0] hist;
    logic [VOTE_DEPTH-1:0] next_hist;
    logic prev_cond;
    logic next_prev_cond;
    logic pin_s;
    logic cond;
    logic hi_sense;
    logic is_level;

    // async routing turns edges into levels of the edge polarity
    assign is_level = level_mode | async_mode;
    assign hi_sense = level_mode ? level_high : edge_rise;
    assign pin_s = sync[SYNC_STAGES-1];
    assign cond = (pin_s == hi_sense);

    // wake path looks at the raw pin so it does not wait on the clock
    assign async_hit = async_mode & (pin == hi_sense);

    // two-stage synchroniser and vote history
    always_comb begin
        next_sync = {sync[SYNC_STAGES-2:0], pin};
        next_hist = {hist[VOTE_DEPTH-2:0], cond};
        next_prev_cond = trig_cond();
    end

    function automatic logic trig_cond();
        // filter bypassed in async mode
        trig_cond = (filter_on & ~async_mode) ? eiu_vote(hist) : cond;
    endfunction : trig_cond

    // edge: condition rises; level: condition stands
    assign trig = is_level ? trig_cond() : (trig_cond() & ~prev_cond);

    always_ff @(posedge clk) begin
        if (rst) begin
            sync <= '0;
            hist <= '0;
            prev_cond <= 1'b0;
        end else begin
            sync <= next_sync;
            hist <= next_hist;
            prev_cond <= next_prev_cond;
        end
    end
endmodule : eiu_sense

// ==== hw/eiu_top.sv ====
// eiu_top: external interrupt unit, pins to interrupt controller
// assumes pins asynchronous, control strobes synchronous to CLK_SYS
// How it works
// - each line picks rise, fall, high or low
// - trigger-type zero is edge, one is level
// - edge polarity zero falling, one rising
// - level bit zero low, one high
// - prop-set unmasks, prop-clear masks a line
// - mask view readable per line
// - pending sticks until cleared or line disabled
// - enable and disable strobes, enable state readable
// - masked trigger still pends and raises wake
// - disabled line holds pending at zero
// - disable strobe also clears pending
// - pins synchronised, two cycles of latency
// - filter takes majority of last three samples
// - async mode makes edges levels, no filter
`timescale 1ns/1ps
module eiu_top (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire eiu_pkg::eiu_lines_t EXT_PIN,
    input wire eiu_pkg::eiu_cfg_s CFG,
    input wire eiu_pkg::eiu_cmd_s CMD,
    output eiu_pkg::eiu_lines_t ENABLE_VIEW,
    output eiu_pkg::eiu_lines_t MASK_VIEW,
    output eiu_pkg::eiu_lines_t PENDING,
    output eiu_pkg::eiu_lines_t IRQ_OUT,
    output logic WAKE_REQUEST_OUT
);
    import eiu_pkg::*;

    eiu_lines_t enabled;
    eiu_lines_t next_enabled;
    eiu_lines_t unmasked;
    eiu_lines_t next_unmasked;
    eiu_lines_t pend;
    eiu_lines_t next_pend;
    eiu_lines_t trig;
    eiu_lines_t async_hit;
    eiu_lines_t trig_d;

    // one sensing slice per line
    for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
        eiu_sense u_sense (
            .clk(CLK_SYS),
            .rst(RST),
            .pin(EXT_PIN[i]),
            .level_mode(CFG.level_mode[i]),
            .edge_rise(CFG.edge_rise[i]),
            .level_high(CFG.level_high[i]),
            .filter_on(CFG.filter_on[i]),
            .async_mode(CFG.async_mode[i]),
            .trig(trig[i]),
            .async_hit(async_hit[i])
        );
    end

    // enable, mask and pending next values; clear wins over set for enable and mask
    always_comb begin
        // set only where a one is written, clear likewise
        next_enabled = (enabled | CMD.enable_set) & ~CMD.enable_clr;
        next_unmasked = (unmasked | CMD.prop_set) & ~CMD.prop_clr;
        next_pend = (pend & ~CMD.pend_clr) | (trig & enabled);
        // disable beats a simultaneous trigger so the flag cannot linger
        next_pend = next_pend & next_enabled;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            enabled <= LINES_RST;
            unmasked <= LINES_RST;
            pend <= LINES_RST;
        end else begin
            enabled <= next_enabled;
            unmasked <= next_unmasked;
            pend <= next_pend;
        end
    end

    assign trig_d = trig & enabled;
    assign ENABLE_VIEW = enabled;
    assign MASK_VIEW = unmasked;
    assign PENDING = pend;
    // masked lines pend but never reach the controller
    assign IRQ_OUT = pend & unmasked;
    // wake from any enabled pending line, or at once from an enabled async pin
    assign WAKE_REQUEST_OUT = |(pend | (async_hit & enabled));

    property p_pend_zero_when_off;
        @(posedge CLK_SYS) disable iff (RST)
        ##1 ((pend & ~enabled) == '0);
    endproperty
    a_pend_zero_when_off: assert property (p_pend_zero_when_off)
        else $error("pending set on disabled line");

    property p_disable_clears;
        @(posedge CLK_SYS) disable iff (RST)
        (CMD.enable_clr != '0) |=> ((pend & $past(CMD.enable_clr)) == '0);
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("disable left pending set");

    property p_trig_sets_pend;
        @(posedge CLK_SYS) disable iff (RST)
        ((trig_d & ~CMD.enable_clr) != '0) |=>
            ((pend & $past(trig_d & ~CMD.enable_clr)) ==
            $past(trig_d & ~CMD.enable_clr));
    endproperty
    a_trig_sets_pend: assert property (p_trig_sets_pend)
        else $error("trigger did not set pending");

    property p_pend_sticky;
        @(posedge CLK_SYS) disable iff (RST)
        (pend[0] && !CMD.pend_clr[0] && !CMD.enable_clr[0]) |=> pend[0];
    endproperty
    a_pend_sticky: assert property (p_pend_sticky)
        else $error("pending dropped without clear");

    property p_masked_no_irq;
        @(posedge CLK_SYS) disable iff (RST)
        ((IRQ_OUT & ~MASK_VIEW) == '0);
    endproperty
    a_masked_no_irq: assert property (p_masked_no_irq)
        else $error("masked line reached controller");

    // a pending line wakes the system whether masked or not
    property p_pend_wakes;
        @(posedge CLK_SYS) disable iff (RST)
        (pend != '0) |-> WAKE_REQUEST_OUT;
    endproperty
    a_pend_wakes: assert property (p_pend_wakes)
        else $error("pending line without wake");

    property p_mask_set_clr;
        @(posedge CLK_SYS) disable iff (RST)
        (CMD.prop_set[0] && !CMD.prop_clr[0]) |=> MASK_VIEW[0] ##1 (MASK_VIEW[0] || $past(CMD.prop_clr[0]));
    endproperty
    a_mask_set_clr: assert property (p_mask_set_clr)
        else $error("mask set strobe lost");

    property p_enable_hold;
        @(posedge CLK_SYS) disable iff (RST)
        (CMD.enable_set == '0 && CMD.enable_clr == '0) |=> $stable(ENABLE_VIEW);
    endproperty
    a_enable_hold: assert property (p_enable_hold)
        else $error("enable changed without strobe");

    property p_enable_set;
        @(posedge CLK_SYS) disable iff (RST)
        (CMD.enable_set[0] && !CMD.enable_clr[0]) |=> ENABLE_VIEW[0];
    endproperty
    a_enable_set: assert property (p_enable_set)
        else $error("enable strobe not taken");

    // a clear strobe drops the flag unless a trigger lands with it
    property p_pend_clear;
        @(posedge CLK_SYS) disable iff (RST)
        ((CMD.pend_clr & ~trig_d) != '0) |=> ((pend & $past(CMD.pend_clr & ~trig_d)) == '0);
    endproperty
    a_pend_clear: assert property (p_pend_clear)
        else $error("pending clear strobe lost");

    // trigger beats a clear in the same cycle so no event is lost
    property p_trig_beats_clear;
        @(posedge CLK_SYS) disable iff (RST)
        ((trig_d & CMD.pend_clr & ~CMD.enable_clr) != '0) |=>
            ((pend & $past(trig_d & CMD.pend_clr & ~CMD.enable_clr)) != '0);
    endproperty
    a_trig_beats_clear: assert property (p_trig_beats_clear)
        else $error("clear swallowed a trigger");

    // no flag appears without an enabled trigger behind it
    property p_pend_needs_trig;
        @(posedge CLK_SYS) disable iff (RST)
        ##1 ((pend & ~$past(pend | trig_d)) == '0);
    endproperty
    a_pend_needs_trig: assert property (p_pend_needs_trig)
        else $error("pending set without trigger");

    // mask clear strobe masks every written line
    property p_mask_clr;
        @(posedge CLK_SYS) disable iff (RST)
        (CMD.prop_clr != '0) |=> ((MASK_VIEW & $past(CMD.prop_clr)) == '0);
    endproperty
    a_mask_clr: assert property (p_mask_clr)
        else $error("mask clear strobe lost");

    // mask set strobe unmasks every written line unless the same line is also cleared
    property p_mask_set_all;
        @(posedge CLK_SYS) disable iff (RST)
        ((CMD.prop_set & ~CMD.prop_clr) != '0) |=>
            ((MASK_VIEW & $past(CMD.prop_set & ~CMD.prop_clr)) ==
            $past(CMD.prop_set & ~CMD.prop_clr));
    endproperty
    a_mask_set_all: assert property (p_mask_set_all)
        else $error("mask set strobe missed a line");

    // mask view only moves on a strobe
    property p_mask_hold;
        @(posedge CLK_SYS) disable iff (RST)
        (CMD.prop_set == '0 && CMD.prop_clr == '0) |=> $stable(MASK_VIEW);
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("mask changed without strobe");

    // disable strobe turns every written line off
    property p_enable_clr;
        @(posedge CLK_SYS) disable iff (RST)
        (CMD.enable_clr != '0) |=> ((ENABLE_VIEW & $past(CMD.enable_clr)) == '0);
    endproperty
    a_enable_clr: assert property (p_enable_clr)
        else $error("disable strobe lost");

    // enable strobe turns every written line on unless the same line is also cleared
    property p_enable_set_all;
        @(posedge CLK_SYS) disable iff (RST)
        ((CMD.enable_set & ~CMD.enable_clr) != '0) |=>
            ((ENABLE_VIEW & $past(CMD.enable_set & ~CMD.enable_clr)) ==
            $past(CMD.enable_set & ~CMD.enable_clr));
    endproperty
    a_enable_set_all: assert property (p_enable_set_all)
        else $error("enable strobe missed a line");

    // an enabled async line at its active level wakes without a clock
    property p_async_wake;
        @(posedge CLK_SYS) disable iff (RST)
        ((async_hit & enabled) != '0) |-> WAKE_REQUEST_OUT;
    endproperty
    a_async_wake: assert property (p_async_wake)
        else $error("async line did not wake");
endmodule : eiu_top

// ==== tb/eiu_far.sv ====
// eiu_far: pin-side model that drives the external interrupt lines
// assumes the bench sets the wanted levels away from the rising edge
`timescale 1ns/1ps
module eiu_far (
    input wire eiu_pkg::eiu_lines_t want,
    output eiu_pkg::eiu_lines_t EXT_PIN
);
    import eiu_pkg::*;
    // pins are actively driven, so no pull level applies between changes
    always_comb begin
        EXT_PIN = want;
    end
endmodule : eiu_far

// ==== tb/testbench.sv ====
// testbench: directed checks of the external interrupt unit
// assumes inputs change at falling edges; pins come from eiu_far
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    import eiu_pkg::*;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    eiu_lines_t want = 8'h05;
    eiu_lines_t EXT_PIN, ENABLE_VIEW, MASK_VIEW, PENDING, IRQ_OUT;
    eiu_cfg_s CFG = '0;
    eiu_cmd_s CMD = '0;
    logic WAKE_REQUEST_OUT;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    eiu_far far (.want(want), .EXT_PIN(EXT_PIN));
    eiu_top dut (.CLK_SYS(CLK_SYS), .RST(RST), .EXT_PIN(EXT_PIN), .CFG(CFG), .CMD(CMD),
        .ENABLE_VIEW(ENABLE_VIEW), .MASK_VIEW(MASK_VIEW), .PENDING(PENDING),
        .IRQ_OUT(IRQ_OUT), .WAKE_REQUEST_OUT(WAKE_REQUEST_OUT));
    // 100 MHz clock
    always #5 CLK_SYS = ~CLK_SYS;
    // hang guard, the whole run needs well under 200 cycles
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge CLK_SYS);
    endtask : tick
    // one-cycle write-one strobe, views settle on the edge it is taken
    task automatic strobe(input eiu_cmd_s c);
        @(negedge CLK_SYS) CMD = c;
        @(negedge CLK_SYS) CMD = '0;
    endtask : strobe
    // lines 0..3: fall, rise, low, high; configured before enabling
    task automatic t_setup();
        CFG = '{level_mode: 8'h0c, edge_rise: 8'h02, level_high: 8'h08,
            filter_on: 8'h00, async_mode: 8'h00};
        strobe('{enable_set: 8'h0f, default: 8'h00});
        `CHK(ENABLE_VIEW, 8'h0f)
        strobe('{prop_set: 8'h05, default: 8'h00});
        `CHK(MASK_VIEW, 8'h05)
        strobe('{prop_clr: 8'h01, default: 8'h00});
        `CHK(MASK_VIEW, 8'h04)
        $display("setup done");
    endtask : t_setup
    // every line flips; disabled lines 4..7 must stay quiet
    task automatic t_trig();
        @(negedge CLK_SYS) want = 8'hfa;
        tick(2);
        `CHK(PENDING, 8'h00)
        tick(1);
        `CHK(PENDING, 8'h0f)
        `CHK(IRQ_OUT, 8'h04)
        `CHK(WAKE_REQUEST_OUT, 1'b1)
        want = 8'h05;
        tick(4);
        `CHK(PENDING, 8'h0f)
        strobe('{pend_clr: 8'h03, default: 8'h00});
        `CHK(PENDING, 8'h0c)
        strobe('{enable_clr: 8'h08, default: 8'h00});
        `CHK(PENDING, 8'h04)
        `CHK(ENABLE_VIEW, 8'h07)
        strobe('{pend_clr: 8'h04, default: 8'h00});
        `CHK(WAKE_REQUEST_OUT, 1'b0)
        $display("trigger done");
    endtask : t_trig
    // single-cycle glitch is voted out, a held level gets through
    task automatic t_filter();
        strobe('{enable_clr: 8'h02, default: 8'h00});
        CFG.filter_on = 8'h02;
        strobe('{enable_set: 8'h02, default: 8'h00});
        want = 8'h07;
        tick(1);
        want = 8'h05;
        tick(6);
        `CHK(PENDING, 8'h00)
        want = 8'h07;
        tick(6);
        `CHK(PENDING, 8'h02)
        want = 8'h05;
        strobe('{pend_clr: 8'h02, default: 8'h00});
        $display("filter done");
    endtask : t_filter
    // async line 0 with rise polarity acts as high level, wake at once
    task automatic t_async();
        strobe('{enable_clr: 8'h01, default: 8'h00});
        CFG.async_mode = 8'h01;
        CFG.edge_rise = 8'h03;
        want = 8'h04;
        strobe('{enable_set: 8'h01, default: 8'h00});
        `CHK(PENDING, 8'h00)
        @(negedge CLK_SYS) want = 8'h05;
        #1;
        `CHK(WAKE_REQUEST_OUT, 1'b1)
        tick(3);
        `CHK(PENDING, 8'h01)
        $display("async done");
    endtask : t_async
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    initial begin
        tick(5);
        RST = 1'b0;
        t_setup();
        t_trig();
        t_filter();
        t_async();
        end_sim();
    end
endmodule : testbench
